// ### dv/tb_tif_intake.sv
// self-checking bench of the translation intake front end
`timescale 1ns/1ps
module tb_tif_intake;
    localparam logic [4:0] UNIT = 5'h03;
    logic ref_clk, sys_rst, spniden, reg_wr, reg_rd;
    logic ar_valid, ar_ready, aw_valid, aw_ready, rns, wns, dec_valid;
    logic ev_access, ev_bypass, ev_fault, g_irq, c_irq;
    logic [9:0] ar_sid, aw_sid;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    tif_pkg::tif_dec_type dec;
    int num_errors = 0;
    int checks_done = 0;

    tif_master_model i_master (.ref_clk(ref_clk), .aw_ready(aw_ready), .ar_valid(ar_valid),
        .ar_sid(ar_sid), .read_nonsecure_sideband(rns), .aw_valid(aw_valid),
        .aw_sid(aw_sid), .write_nonsecure_sideband(wns));

    tif_intake #(.SID_W(10), .UNIT_ID(UNIT)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .ar_valid(ar_valid), .ar_ready(ar_ready), .ar_sid(ar_sid), .read_nonsecure_sideband(rns),
        .aw_valid(aw_valid), .aw_ready(aw_ready), .aw_sid(aw_sid),
        .write_nonsecure_sideband(wns), .spniden(spniden), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dec_valid(dec_valid), .dec(dec), .ev_access(ev_access), .ev_bypass(ev_bypass),
        .ev_fault(ev_fault), .global_fault_irq(g_irq), .context_fault_irq(c_irq));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wreg

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask : rchk

    // f is {bypass, fault, global}; t is {treat, ctx, big endian}, judged only when full
    task automatic txn(input logic wr, input logic [9:0] sid, input logic ns,
                       input logic [2:0] f, input logic [4:0] t, input bit full);
        int n;
        logic act;
        i_master.send(wr, sid, ns);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (dec_valid !== 1'b1 && n < 6);
        act = ns | spniden;
        // the decision pulse shows one edge after the edge that takes the address
        chk("latency", n, 1);
        if (dec_valid !== 1'b1) stop_test();
        chk("ready", {ar_ready, aw_ready}, 2'b11);
        chk("decision", {dec.secure, dec.is_write, dec.bypass, dec.fault, dec.global_fault},
            {~ns, wr, f});
        chk("sid", dec.sid, {UNIT, sid});
        chk("events", {ev_access, ev_bypass, ev_fault}, {act, act & f[2], act & f[1]});
        if (full) chk("treatment", {dec.treat, dec.ctx, dec.big_endian}, t);
    endtask : txn

    task automatic t_global();
        rchk("cfg", tif_pkg::CFG_SEC_OFS, 0);
        rchk("unmapped", 8'h80, 0);
        txn(0, 10'h003, 1, 3'b011, 0, 0);
        rchk("gfsr", tif_pkg::GFSR_OFS, 1);
        chk("irq off", g_irq, 0);
        wreg(tif_pkg::CFG_NSEC_OFS, 32'h0000_0002);
        chk("irq on", g_irq, 1);
        wreg(tif_pkg::GFSR_OFS, 32'h0000_0007);
        rchk("gfsr clr", tif_pkg::GFSR_OFS, 0);
        chk("irq clr", g_irq, 0);
        $display("test global done");
    endtask : t_global

    task automatic t_client();
        wreg(tif_pkg::CFG_SEC_OFS, 32'h0000_0001);
        txn(1, 10'h007, 0, 3'b100, 0, 0);
        txn(0, 10'h007, 1, 3'b011, 0, 0);
        wreg(tif_pkg::CFG_SEC_OFS, 0);
        wreg(tif_pkg::GFSR_OFS, 32'h0000_0001);
        $display("test client done");
    endtask : t_client

    task automatic t_table();
        wreg(tif_pkg::CB_CTRL_BASE + 8'h04, 32'h0000_0003);
        for (int t = 0; t < 4; t++) begin
            wreg(tif_pkg::SME_BASE, {1'b1, 12'h000, 2'(t), 2'b01, UNIT, 10'h005});
            txn(0, 10'h005, 1, (t == 0) ? 3'b100 : 3'b000, {2'(t), 3'b011}, 1);
        end
        wreg(tif_pkg::CB_CTRL_BASE + 8'h04, 32'h0000_0004);
        txn(1, 10'h005, 1, 3'b010, 5'b11010, 1);
        rchk("cb fsr", tif_pkg::CB_FSR_BASE + 8'h04, 1);
        chk("ctx irq", c_irq, 1);
        wreg(tif_pkg::CB_FSR_BASE + 8'h04, 32'h0000_0001);
        chk("ctx irq clr", c_irq, 0);
        $display("test table done");
    endtask : t_table

    task automatic t_mode();
        wreg(tif_pkg::CFG_NSEC_OFS, 32'h0000_0004);
        txn(0, 10'h005, 1, 3'b100, 0, 0);
        wreg(tif_pkg::CFG_NSEC_OFS, 32'h0000_0008);
        txn(1, 10'h005, 1, 3'b011, 0, 0);
        rchk("gfsr forced", tif_pkg::GFSR_OFS, 4);
        txn(1, 10'h009, 0, 3'b011, 0, 0);
        spniden <= 1'b1;
        repeat (4) @(posedge ref_clk);
        txn(0, 10'h009, 0, 3'b011, 0, 0);
        // secure set in bypass while the other set faults: only the secure set may steer
        wreg(tif_pkg::CFG_SEC_OFS, 32'h0000_0006);
        txn(1, 10'h009, 0, 3'b100, 0, 0);
        wreg(tif_pkg::CFG_SEC_OFS, 32'h0000_000A);
        txn(0, 10'h009, 0, 3'b011, 0, 0);
        chk("irq sec", g_irq, 1);
        rchk("status", tif_pkg::STATUS_OFS, {14'h0, 1'b1, 1'b0, 1'b0, UNIT, 10'h009});
        $display("test mode done");
    endtask : t_mode

    initial begin
        #1000000;
        num_errors++;
        stop_test();
    end

    initial begin
        sys_rst = 1'b1;
        spniden = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_global();
        t_client();
        t_table();
        t_mode();
        stop_test();
    end
endmodule : tb_tif_intake

// ### dv/tif_master_model.sv
// upstream master model: address valid with stream and security sideband
`timescale 1ns/1ps
module tif_master_model (
    input wire logic ref_clk,
    input wire logic aw_ready,
    output logic ar_valid,
    output logic [9:0] ar_sid,
    output logic read_nonsecure_sideband,
    output logic aw_valid,
    output logic [9:0] aw_sid,
    output logic write_nonsecure_sideband
);
    initial begin
        ar_valid = 1'b0;
        aw_valid = 1'b0;
        ar_sid = 10'h000;
        aw_sid = 10'h3FF;
        read_nonsecure_sideband = 1'b0;
        write_nonsecure_sideband = 1'b1;
    end

    task automatic send(input logic wr, input logic [9:0] sid, input logic ns);
        @(posedge ref_clk);
        if (wr) begin
            aw_valid <= 1'b1;
            aw_sid <= sid;
            write_nonsecure_sideband <= ns;
        end else begin
            ar_valid <= 1'b1;
            ar_sid <= sid;
            read_nonsecure_sideband <= ns;
        end
        @(posedge ref_clk);
        while (wr && aw_ready !== 1'b1) @(posedge ref_clk);
        ar_valid <= 1'b0;
        aw_valid <= 1'b0;
        // released lines flip so a stale sideband can never pass for a sampled one
        ar_sid <= ~ar_sid;
        aw_sid <= ~aw_sid;
        read_nonsecure_sideband <= ~read_nonsecure_sideband;
        write_nonsecure_sideband <= ~write_nonsecure_sideband;
    endtask : send
endmodule : tif_master_model

// ### rtl/tif_intake.sv
// translation intake front end: sideband capture, bypass/translate decision, fault records
// Functional notes
// [RL1] the stream identifier is captured with every accepted address on either channel.
// [RL2] the non-secure sideband is captured with every accepted address the same way.
// [RL3] security is decided first, then context, then walk, checks and attributes downstream.
// [RL4] a config mode can bypass or fault every transaction whatever its translation.
// [RL5] a secure originator uses the secure config set, a non-secure one the other set.
// [RL6] client_disable in the selected config passes the transaction untranslated; in fault mode the code faults it instead.
// [RL7] a matched stream gets bypass, stage 1, stage 2 or stage 1 then stage 2.
// [RL8] faults before context mapping go to global status, later ones to the context status.
// [RL9] a recorded fault raises an interrupt when enabled; software clears the status bit.
// [RL10] the config access fault flag always reads zero and ignores writes.
// [RL11] each context bank selects little or big endian table walks.
// [RL12] the stream identifier width is 1 to 10 bits or exactly 15 bits.
// [RL13] the master drives separate stream identifier lines for read and write addresses.
// [RL14] the stream identifier is looked up in the stream match table to find the context.
// [RL15] secure events count only while spniden is high; events leave on event outputs.
// [RL16] the non-secure sideband is 0 for a secure and 1 for a non-secure access.
// [RL17] a narrow identifier is zero-extended to 10 bits behind a 5-bit unit number.
`timescale 1ns/1ps
module tif_intake #(
    parameter int SID_W = 10,
    parameter logic [tif_pkg::UNIT_W-1:0] UNIT_ID = 5'h00
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ar_valid,
    output logic ar_ready,
    input wire logic [SID_W-1:0] ar_sid,
    input wire logic read_nonsecure_sideband,
    input wire logic aw_valid,
    output logic aw_ready,
    input wire logic [SID_W-1:0] aw_sid,
    input wire logic write_nonsecure_sideband,
    input wire logic spniden,
    input wire logic [tif_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic dec_valid,
    output tif_pkg::tif_dec_type dec,
    output logic ev_access,
    output logic ev_bypass,
    output logic ev_fault,
    output logic global_fault_irq,
    output logic context_fault_irq
);
    function automatic logic [tif_pkg::ID_W-1:0] form_id(input logic [SID_W-1:0] sid);
        if (SID_W == tif_pkg::ID_W) begin
            form_id = tif_pkg::ID_W'(sid);
        end else begin
            form_id = {UNIT_ID, tif_pkg::NARROW_W'(sid)}; // see [RL17]
        end
    endfunction : form_id

    // hit on a bank of four word registers at base
    function automatic logic bank_hit(input logic [7:0] addr, input logic [7:0] base);
        bank_hit = (addr[7:4] == base[7:4]);
    endfunction : bank_hit

    function automatic logic [2:0] w1c(input logic [2:0] old, input logic [2:0] set,
                                       input logic [2:0] clr);
        w1c = set | (old & ~clr);
    endfunction : w1c

    logic [tif_pkg::ID_W-1:0] ar_id15;
    logic [tif_pkg::ID_W-1:0] aw_id15;
    logic spn_meta;
    logic spn_sync;
    logic cap_valid;
    logic next_cap_valid;
    tif_pkg::tif_txn_type cap;
    tif_pkg::tif_txn_type next_cap;
    logic [3:0] cfg_sec;
    logic [3:0] cfg_nsec;
    logic [3:0] next_cfg_sec;
    logic [3:0] next_cfg_nsec;
    logic [2:0] gfsr;
    logic [2:0] next_gfsr;
    logic [2:0] cb_ctrl [tif_pkg::NUM_CTX];
    logic [2:0] next_cb_ctrl [tif_pkg::NUM_CTX];
    logic [2:0] cb_fsr [tif_pkg::NUM_CTX];
    logic [2:0] next_cb_fsr [tif_pkg::NUM_CTX];
    tif_pkg::tif_txn_type last;
    tif_pkg::tif_txn_type next_last;
    logic next_dec_valid;
    tif_pkg::tif_dec_type next_dec;
    logic next_ev_access;
    logic next_ev_bypass;
    logic next_ev_fault;
    logic [31:0] next_rdata;
    logic [3:0] sel_cfg;
    tif_pkg::tif_mode_type mode;
    logic sme_hit;
    tif_pkg::tif_sme_type sme_entry;
    logic [31:0] sme_rdata;
    logic [2:0] gfsr_set;
    logic [tif_pkg::NUM_CTX-1:0] ctx_fault_set;
    logic [tif_pkg::NUM_CTX-1:0] ctx_irq;

    assign ar_id15 = form_id(ar_sid);
    assign aw_id15 = form_id(aw_sid);

    // reads always win the single intake slot; writes wait for as long as ar_valid is high
    assign ar_ready = 1'b1;
    assign aw_ready = !ar_valid;

    // spniden is a pin, so it is synchronised before use
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            spn_meta <= 1'b0;
            spn_sync <= 1'b0;
        end else begin
            spn_meta <= spniden;
            spn_sync <= spn_meta;
        end
    end

    // separate read and write sideband lines feed the capture stage see [RL13]
    always_comb begin
        next_cap_valid = ar_valid || aw_valid;
        next_cap = cap;
        if (ar_valid) begin
            next_cap.sid = ar_id15; // see [RL1]
            next_cap.ns = read_nonsecure_sideband; // see [RL2]
            next_cap.is_write = 1'b0;
        end else if (aw_valid) begin
            next_cap.sid = aw_id15; // see [RL1]
            next_cap.ns = write_nonsecure_sideband; // see [RL2]
            next_cap.is_write = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cap_valid <= 1'b0;
            cap <= '0;
        end else begin
            cap_valid <= next_cap_valid;
            cap <= next_cap;
        end
    end

    tif_stream_table u_table (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_en(reg_wr && bank_hit(reg_addr, tif_pkg::SME_BASE)),
        .wr_idx(reg_addr[3:2]),
        .wr_data(reg_wdata),
        .rd_idx(reg_addr[3:2]),
        .rd_data(sme_rdata),
        .look_id(cap.sid),
        .hit(sme_hit),
        .hit_entry(sme_entry)
    );

    // security first, then config set, then stream match and context see [RL3]
    always_comb begin
        sel_cfg = cap.ns ? cfg_nsec : cfg_sec; // see [RL5] [RL16]
        mode = tif_pkg::tif_mode_type'(sel_cfg[tif_pkg::CFG_MODE_LSB +: 2]);
        gfsr_set = '0;
        ctx_fault_set = '0;
        next_dec = '0;
        next_dec.secure = !cap.ns; // see [RL16]
        next_dec.is_write = cap.is_write;
        next_dec.sid = cap.sid;
        next_dec.treat = tif_pkg::TREAT_BYPASS;
        if (mode == tif_pkg::MODE_BYPASS) begin
            next_dec.bypass = 1'b1; // see [RL4]
        end else if (mode == tif_pkg::MODE_FAULT) begin
            next_dec.fault = 1'b1; // see [RL4]
            next_dec.global_fault = 1'b1;
            gfsr_set[tif_pkg::GFSR_FORCED_BIT] = 1'b1; // see [RL8]
        end else if (sel_cfg[tif_pkg::CFG_CLIENT_DIS_BIT]) begin
            next_dec.bypass = 1'b1; // see [RL6]
        end else if (!sme_hit) begin
            // unmatched stream: no context yet, so the fault is global
            next_dec.fault = 1'b1;
            next_dec.global_fault = 1'b1;
            gfsr_set[tif_pkg::GFSR_UNMATCHED_BIT] = 1'b1; // see [RL8]
        end else begin
            next_dec.ctx = sme_entry.ctx; // see [RL14]
            next_dec.treat = sme_entry.treat; // see [RL7]
            next_dec.bypass = (sme_entry.treat == tif_pkg::TREAT_BYPASS);
            next_dec.big_endian = cb_ctrl[sme_entry.ctx][tif_pkg::CB_BIG_END_BIT]; // see [RL11]
            if (!next_dec.bypass && !cb_ctrl[sme_entry.ctx][tif_pkg::CB_ENABLE_BIT]) begin
                next_dec.fault = 1'b1;
                ctx_fault_set[sme_entry.ctx] = 1'b1; // see [RL8]
            end
        end
        if (!cap_valid) begin
            gfsr_set = '0;
            ctx_fault_set = '0;
        end
        next_dec_valid = cap_valid;
        // secure events are hidden unless non-invasive debug is allowed
        next_ev_access = cap_valid && (cap.ns || spn_sync); // see [RL15]
        next_ev_bypass = next_ev_access && next_dec.bypass;
        next_ev_fault = next_ev_access && next_dec.fault;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dec_valid <= 1'b0;
            dec <= '0;
            ev_access <= 1'b0;
            ev_bypass <= 1'b0;
            ev_fault <= 1'b0;
        end else begin
            dec_valid <= next_dec_valid;
            dec <= next_dec;
            ev_access <= next_ev_access;
            ev_bypass <= next_ev_bypass;
            ev_fault <= next_ev_fault;
        end
    end

    // register writes; a fault in the clearing cycle still sets its bit
    always_comb begin
        next_cfg_sec = cfg_sec;
        next_cfg_nsec = cfg_nsec;
        next_last = cap_valid ? cap : last;
        next_gfsr = w1c(gfsr, gfsr_set, (reg_wr && reg_addr == tif_pkg::GFSR_OFS) ?
                        reg_wdata[2:0] : 3'h0); // see [RL9]
        next_gfsr[tif_pkg::GFSR_CFG_ACCESS_BIT] = 1'b0; // see [RL10]
        for (int i = 0; i < tif_pkg::NUM_CTX; i++) begin
            next_cb_ctrl[i] = cb_ctrl[i];
            next_cb_fsr[i] = cb_fsr[i] | {2'h0, ctx_fault_set[i]};
        end
        if (reg_wr) begin
            if (reg_addr == tif_pkg::CFG_SEC_OFS) begin
                next_cfg_sec = reg_wdata[3:0];
            end
            if (reg_addr == tif_pkg::CFG_NSEC_OFS) begin
                next_cfg_nsec = reg_wdata[3:0];
            end
            if (bank_hit(reg_addr, tif_pkg::CB_CTRL_BASE)) begin
                next_cb_ctrl[reg_addr[3:2]] = reg_wdata[2:0];
            end
            if (bank_hit(reg_addr, tif_pkg::CB_FSR_BASE)) begin
                next_cb_fsr[reg_addr[3:2]] = w1c(cb_fsr[reg_addr[3:2]],
                    {2'h0, ctx_fault_set[reg_addr[3:2]]}, {2'h0, reg_wdata[0]}); // see [RL9]
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_sec <= tif_pkg::CFG_RESET;
            cfg_nsec <= tif_pkg::CFG_RESET;
            gfsr <= tif_pkg::GFSR_RESET;
            last <= '0;
            for (int i = 0; i < tif_pkg::NUM_CTX; i++) begin
                cb_ctrl[i] <= tif_pkg::CB_CTRL_RESET;
                cb_fsr[i] <= tif_pkg::GFSR_RESET;
            end
        end else begin
            cfg_sec <= next_cfg_sec;
            cfg_nsec <= next_cfg_nsec;
            gfsr <= next_gfsr;
            last <= next_last;
            for (int i = 0; i < tif_pkg::NUM_CTX; i++) begin
                cb_ctrl[i] <= next_cb_ctrl[i];
                cb_fsr[i] <= next_cb_fsr[i];
            end
        end
    end

    // read data is registered and stands only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == tif_pkg::CFG_SEC_OFS) begin
                next_rdata = {28'h0, cfg_sec};
            end else if (reg_addr == tif_pkg::CFG_NSEC_OFS) begin
                next_rdata = {28'h0, cfg_nsec};
            end else if (reg_addr == tif_pkg::GFSR_OFS) begin
                next_rdata = {29'h0, gfsr[2], 1'b0, gfsr[0]}; // see [RL10]
            end else if (reg_addr == tif_pkg::STATUS_OFS) begin
                next_rdata = {14'h0, spn_sync, last.ns, 1'b0, last.sid};
            end else if (bank_hit(reg_addr, tif_pkg::CB_CTRL_BASE)) begin
                next_rdata = {29'h0, cb_ctrl[reg_addr[3:2]]};
            end else if (bank_hit(reg_addr, tif_pkg::CB_FSR_BASE)) begin
                next_rdata = {29'h0, cb_fsr[reg_addr[3:2]]};
            end else if (bank_hit(reg_addr, tif_pkg::SME_BASE)) begin
                next_rdata = sme_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    always_comb begin
        for (int i = 0; i < tif_pkg::NUM_CTX; i++) begin
            ctx_irq[i] = cb_fsr[i][tif_pkg::CB_FSR_DISABLED_BIT] &&
                         cb_ctrl[i][tif_pkg::CB_IRQ_EN_BIT];
        end
    end

    assign global_fault_irq = (|gfsr) && (cfg_sec[tif_pkg::CFG_IRQ_EN_BIT] ||
                              cfg_nsec[tif_pkg::CFG_IRQ_EN_BIT]); // see [RL9]
    assign context_fault_irq = |ctx_irq; // see [RL9]

    sid_width_a: assert property ( // see [RL12]
        @(posedge ref_clk) disable iff (sys_rst)
        (SID_W >= 1 && SID_W <= 10) || SID_W == 15)
        else $error("stream identifier width out of range");

    capture_sid_a: assert property ( // see [RL1]
        @(posedge ref_clk) disable iff (sys_rst)
        ar_valid |=> ##1 (dec_valid && dec.sid == $past(ar_id15, 2)))
        else $error("read stream identifier not carried to the decision");

    capture_ns_a: assert property ( // see [RL2]
        @(posedge ref_clk) disable iff (sys_rst)
        (aw_valid && !ar_valid) |=> ##1 (dec.secure == !$past(write_nonsecure_sideband, 2)))
        else $error("write security sideband not carried to the decision");

    decide_latency_a: assert property ( // see [RL3]
        @(posedge ref_clk) disable iff (sys_rst)
        (ar_valid || aw_valid) |-> ##2 dec_valid)
        else $error("decision not two cycles after the address");

    forced_fault_a: assert property ( // see [RL4]
        @(posedge ref_clk) disable iff (sys_rst)
        (cap_valid && mode == tif_pkg::MODE_FAULT) |=> (dec.fault && gfsr[2]))
        else $error("fault mode did not fault and record");

    client_bypass_a: assert property ( // see [RL6]
        @(posedge ref_clk) disable iff (sys_rst)
        (cap_valid && mode == tif_pkg::MODE_NORMAL && sel_cfg[0]) |=> (dec.bypass && !dec.fault))
        else $error("client disable did not bypass");

    secure_set_a: assert property ( // see [RL5]
        @(posedge ref_clk) disable iff (sys_rst)
        (cap_valid && !cap.ns && cfg_sec[3:2] == 2'h1) |=> (dec.bypass && dec.secure))
        else $error("secure transaction not steered by secure config");

    global_record_a: assert property ( // see [RL8]
        @(posedge ref_clk) disable iff (sys_rst)
        (dec_valid && dec.global_fault) |-> (gfsr[0] || gfsr[2]))
        else $error("pre-context fault not in global status");

    irq_raise_a: assert property ( // see [RL9]
        @(posedge ref_clk) disable iff (sys_rst)
        (dec_valid && dec.global_fault && cfg_sec[1]) |-> global_fault_irq)
        else $error("recorded fault raised no interrupt");

    cfg_access_zero_a: assert property ( // see [RL10]
        @(posedge ref_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == tif_pkg::GFSR_OFS) |=> !reg_rdata[1])
        else $error("config access fault flag read as one");

    secure_event_a: assert property ( // see [RL15]
        @(posedge ref_clk) disable iff (sys_rst)
        (ev_access && dec.secure) |-> $past(spn_sync))
        else $error("secure event counted without spniden");

    unit_prefix_a: assert property ( // see [RL17]
        @(posedge ref_clk) disable iff (sys_rst)
        (dec_valid && SID_W < 15) |-> (dec.sid[14:10] == UNIT_ID))
        else $error("unit number missing from identifier");
endmodule : tif_intake

// ### rtl/tif_pkg.sv
// shared constants and types of the translation intake front end
package tif_pkg;
    localparam int ID_W = 15;
    localparam int NARROW_W = 10;
    localparam int UNIT_W = 5;
    localparam int CTX_W = 2;
    localparam int NUM_CTX = 4;
    localparam int NUM_SME = 4;
    localparam int ADDR_W = 8;

    // register offsets (byte addresses; one word each, the three bases start banks of four words)
    localparam logic [7:0] CFG_SEC_OFS = 8'h00;
    localparam logic [7:0] CFG_NSEC_OFS = 8'h04;
    localparam logic [7:0] GFSR_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] CB_CTRL_BASE = 8'h20;
    localparam logic [7:0] CB_FSR_BASE = 8'h30;
    localparam logic [7:0] SME_BASE = 8'h40;

    // config register fields
    localparam int CFG_CLIENT_DIS_BIT = 0;
    localparam int CFG_IRQ_EN_BIT = 1;
    localparam int CFG_MODE_LSB = 2;
    // global fault status fields
    localparam int GFSR_UNMATCHED_BIT = 0;
    localparam int GFSR_CFG_ACCESS_BIT = 1;
    localparam int GFSR_FORCED_BIT = 2;
    // context bank control fields
    localparam int CB_ENABLE_BIT = 0;
    localparam int CB_BIG_END_BIT = 1;
    localparam int CB_IRQ_EN_BIT = 2;
    // context fault status fields
    localparam int CB_FSR_DISABLED_BIT = 0;
    // status register fields
    localparam int STATUS_NS_BIT = 16;
    localparam int STATUS_SPN_BIT = 17;

    // values after reset
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam logic [2:0] GFSR_RESET = 3'h0;
    localparam logic [2:0] CB_CTRL_RESET = 3'h0;
    localparam logic [31:0] SME_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {TREAT_BYPASS, TREAT_S1, TREAT_S2, TREAT_S1S2} tif_treat_type;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_BYPASS, MODE_FAULT, MODE_SPARE} tif_mode_type;

    // captured address sideband
    typedef struct packed {
        logic ns;
        logic is_write;
        logic [ID_W-1:0] sid;
    } tif_txn_type;

    // stream match entry as held in its register
    typedef struct packed {
        logic valid;
        logic [11:0] rsvd;
        tif_treat_type treat;
        logic [CTX_W-1:0] ctx;
        logic [ID_W-1:0] id;
    } tif_sme_type;

    // decision handed to the translation stages
    typedef struct packed {
        logic secure;
        logic is_write;
        logic bypass;
        logic fault;
        logic global_fault;
        tif_treat_type treat;
        logic [CTX_W-1:0] ctx;
        logic big_endian;
        logic [ID_W-1:0] sid;
    } tif_dec_type;
endpackage : tif_pkg

// ### rtl/tif_stream_table.sv
// stream match table: entry storage and lowest-index lookup
`timescale 1ns/1ps
module tif_stream_table (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [tif_pkg::CTX_W-1:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [tif_pkg::CTX_W-1:0] rd_idx,
    output logic [31:0] rd_data,
    input wire logic [tif_pkg::ID_W-1:0] look_id,
    output logic hit,
    output tif_pkg::tif_sme_type hit_entry
);
    tif_pkg::tif_sme_type entry [tif_pkg::NUM_SME];
    tif_pkg::tif_sme_type next_entry [tif_pkg::NUM_SME];

    always_comb begin
        for (int i = 0; i < tif_pkg::NUM_SME; i++) begin
            next_entry[i] = entry[i];
        end
        if (wr_en) begin
            next_entry[wr_idx] = tif_pkg::tif_sme_type'(wr_data);
            // reserved bits are not stored so they read as zero
            next_entry[wr_idx].rsvd = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < tif_pkg::NUM_SME; i++) begin
                entry[i] <= tif_pkg::tif_sme_type'(tif_pkg::SME_RESET);
            end
        end else begin
            for (int i = 0; i < tif_pkg::NUM_SME; i++) begin
                entry[i] <= next_entry[i];
            end
        end
    end

    assign rd_data = 32'(entry[rd_idx]);

    // lowest matching index wins, so overlapping entries resolve predictably
    always_comb begin
        hit = 1'b0;
        hit_entry = tif_pkg::tif_sme_type'(tif_pkg::SME_RESET);
        for (int i = tif_pkg::NUM_SME - 1; i >= 0; i--) begin
            if (entry[i].valid && entry[i].id == look_id) begin // see [RL14]
                hit = 1'b1;
                hit_entry = entry[i];
            end
        end
    end
endmodule : tif_stream_table
